//--- dv/i2c_link_sva.sv
`timescale 1ns/100ps
// ==========================================================
// link checker, watches the shared two-wire link
module i2c_link_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_oe,
	input wire logic unlocked
);
	logic scl_q;
	logic sda_q;
	logic frame_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// ==========================================================
	// frame tracking: open on start, close on stop
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			frame_q <= 1'b0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda_q && !sda)
				frame_q <= 1'b1;
			else if (scl && scl_q && !sda_q && sda)
				frame_q <= 1'b0;
		end
	end

	// ==========================================================
	// properties
	a_unlock_sticky: assert property (unlocked |=> unlocked)
		else $error("unlock dropped without reset");
	a_unlock_in_frame: assert property ($rose(unlocked) |-> frame_q)
		else $error("unlock outside a write frame");
	a_drive_scl_low: assert property ($rose(sda_d_oe) |-> !scl)
		else $error("target began driving while clock high");
	a_release_scl_low: assert property ($fell(sda_d_oe) |-> !scl)
		else $error("target released while clock high");
	a_hold_scl_high: assert property (
		scl && $past(scl) |-> $stable(sda_d_oe))
		else $error("target data moved while clock high");
	a_quiet_outside: assert property (!frame_q |-> !sda_d_oe)
		else $error("target drives outside a frame");
	a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
		else $error("clock low phase too short");
	a_scl_high_min: assert property ($rose(scl) |=> scl [*7])
		else $error("clock high phase too short");
endmodule

//--- dv/tb_sensor_i2c_register_port.sv
`timescale 1ns/100ps
// ==========================================================
// bench: controller and target joined over one link
module tb_sensor_i2c_register_port;
	import i2c_port_pkg::*;
	logic        ref_clk;
	logic        rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pin_lo;
	logic        pin_hi;
	logic [11:0] x_data;
	logic [11:0] y_data;
	logic [11:0] z_data;
	logic [11:0] temp_data;
	logic        unlocked;
	logic [1:0]  sleep_mode;
	logic [31:0] rdat;
	logic [31:0] stat;
	logic [31:0] loop_word;
	int          errors;
	int          tests_run;

	// expected first word of a looped read
	assign loop_word = {x_data[11:4], y_data[11:4], z_data[11:4],
		2'b00, temp_data[11:6]};

	i2c_link_if link ();

	sensor_i2c_target u_sensor_i2c_target (
		.ref_clk              (ref_clk),
		.rst                  (rst),
		.bus                  (link),
		.addr_select_pin_low  (pin_lo),
		.addr_select_pin_high (pin_hi),
		.x_data               (x_data),
		.y_data               (y_data),
		.z_data               (z_data),
		.temp_data            (temp_data),
		.unlocked             (unlocked),
		.sleep_mode           (sleep_mode)
	);

	i2c_bus_controller u_i2c_bus_controller (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.bus             (link)
	);

	i2c_link_sva u_i2c_link_sva (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.scl      (link.scl),
		.sda      (link.sda),
		.sda_d_oe (link.sda_d_oe),
		.unlocked (unlocked)
	);

	// ==========================================================
	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// helpers
	task automatic give_verdict();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask

	// one avalon access, held until waitrequest is seen low
	task automatic av(input logic rd, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= rd;
		avs_write <= ~rd;
		avs_writedata <= d;
		@(posedge ref_clk);
		// only the watchdog ends a wait that never comes
		while (avs_waitrequest !== 1'b0)
			@(posedge ref_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// one link transfer through the controller, polled to completion
	task automatic xfer(input logic rd, input logic [6:0] tg,
		input logic [7:0] r, input logic [31:0] w, input logic c);
		int n;
		logic [31:0] s;
		if (!rd)
			av(1'b0, AV_WDATA, w, s);
		av(1'b0, AV_CMD, {7'h0, c, 1'b0, tg, r, 7'h0, rd}, s);
		n = 0;
		s = 32'h1;
		while (s[0] !== 1'b0 && n < 3000)
		begin
			av(1'b1, AV_STATUS, 32'h0, s);
			n++;
		end
		chk({31'h0, s[0]}, 32'h0);
		stat = s;
		av(1'b1, AV_RDATA, 32'h0, rdat);
	endtask

	// bitwise crc, msb first, zero start, x8+x2+x+1
	function automatic logic [7:0] crc8(input logic [47:0] s);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 47; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ s[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	// ==========================================================
	// main sequence
	initial
	begin
		errors = 0;
		tests_run = 0;
		rst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		pin_lo = 1'b0;
		pin_hi = 1'b0;
		x_data = 12'hABC;
		y_data = 12'h123;
		z_data = 12'h456;
		temp_data = 12'hFED;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		av(1'b0, AV_DIV, 32'h8, rdat);
		chk({31'h0, unlocked}, 32'h0);
		xfer(1'b0, ADDR_BASE, REG_SLEEP, 32'h1, 1'b0);
		chk({30'h0, sleep_mode}, 32'h1);
		xfer(1'b0, ADDR_BASE, 8'h10, 32'hA5A5A5A5, 1'b0);
		xfer(1'b1, ADDR_BASE, 8'h10, 32'h0, 1'b0);
		chk(rdat, 32'h0);
		xfer(1'b1, ADDR_BASE, REG_SLEEP, 32'h0, 1'b0);
		chk(rdat, 32'h1);
		xfer(1'b0, ADDR_BASE, REG_KEY, KEY_VALUE, 1'b0);
		chk({31'h0, unlocked}, 32'h1);
		xfer(1'b0, ADDR_BASE, REG_KEY, 32'h0, 1'b0);
		chk({31'h0, unlocked}, 32'h1);
		xfer(1'b0, ADDR_BASE, 8'h10, 32'hA5A5A5A5, 1'b0);
		xfer(1'b1, ADDR_BASE, 8'h10, 32'h0, 1'b0);
		chk(rdat, 32'hA5A5A5A5);
		chk({31'h0, stat[1]}, 32'h0);
		xfer(1'b1, ADDR_BASE + 7'h1, 8'h10, 32'h0, 1'b0);
		chk({31'h0, stat[1]}, 32'h1);
		// acked fourth byte runs on into the next register
		xfer(1'b0, ADDR_BASE, 8'h11, 32'h3C000000, 1'b0);
		xfer(1'b1, ADDR_BASE, 8'h10, 32'h0, 1'b1);
		chk(rdat, 32'hA5A5A5A5);
		chk({24'h0, stat[15:8]}, 32'h0000003C);
		// crc on, stored address 3A
		xfer(1'b0, ADDR_BASE, REG_CFG, 32'h0004E800, 1'b0);
		xfer(1'b1, ADDR_BASE, 8'h10, 32'h0, 1'b1);
		chk({24'h0, stat[15:8]},
			{24'h0, crc8({8'h10, ADDR_BASE, 1'b1, 32'hA5A5A5A5})});
		// every loop code, single codes read the plain register
		for (int m = 0; m < 4; m++)
		begin
			xfer(1'b0, ADDR_BASE, REG_SLEEP, {28'h0, m[1:0], 2'b01},
				1'b0);
			xfer(1'b1, ADDR_BASE, 8'h10, 32'h0, 1'b1);
			chk(rdat, (m == 1 || m == 2) ? loop_word : 32'hA5A5A5A5);
		end
		chk({30'h0, sleep_mode}, 32'h1);
		// low bits word read plainly in single mode
		xfer(1'b1, ADDR_BASE, REG_AUX, 32'h0, 1'b1);
		chk(rdat, {14'h0, temp_data[5:0], x_data[3:0],
			y_data[3:0], z_data[3:0]});
		// both straps high selects the stored address
		pin_lo <= 1'b1;
		pin_hi <= 1'b1;
		repeat (4) @(posedge ref_clk);
		xfer(1'b1, 7'h3A, 8'h10, 32'h0, 1'b1);
		chk(rdat, 32'hA5A5A5A5);
		chk({24'h0, stat[15:8]},
			{24'h0, crc8({8'h10, 7'h3A, 1'b1, 32'hA5A5A5A5})});
		// power cycle closes the unlock
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk({31'h0, unlocked}, 32'h0);
		give_verdict();
	end

	// ==========================================================
	// watchdog
	initial
	begin
		repeat (90000) @(posedge ref_clk);
		errors++;
		$display("FAIL %0t run did not finish", $time);
		give_verdict();
	end
endmodule

//--- verilog/i2c_bus_controller.sv
`timescale 1ns/100ps
// two-wire bus controller driven by software over avalon-mm
module i2c_bus_controller
	import i2c_port_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	i2c_link_if.host         bus
);

	typedef struct packed {
		logic [1:0]  sda_s;
		logic        wait_q;
		logic [31:0] rdata;
		logic        op_rd;
		logic [7:0]  reg_a;
		logic [6:0]  tgt;
		logic        crc_on;
		logic [31:0] wdata;
		logic [31:0] rxdata;
		logic [7:0]  crc_rx;
		logic        busy;
		logic        nack;
		logic [15:0] div;
		logic [15:0] cnt;
		host_state_t st;
		logic [1:0]  ph;
		logic [3:0]  bitc;
		logic [2:0]  k;
		logic [7:0]  sh;
		logic        scl_oe;
		logic        sda_oe;
	} host_s_t;

	host_s_t s;
	host_s_t n;

	// byte sent at step k of a transfer
	function automatic logic [7:0] tx_byte(input logic [2:0] k,
		input logic rd, input logic [6:0] t, input logic [7:0] r,
		input logic [31:0] w);
		case (k)
			3'd0:    tx_byte = {t, 1'b0};
			3'd1:    tx_byte = r;
			3'd2:    tx_byte = rd ? {t, 1'b1} : w[31:24];
			3'd3:    tx_byte = w[23:16];
			3'd4:    tx_byte = w[15:8];
			3'd5:    tx_byte = w[7:0];
			default: tx_byte = 8'hFF;
		endcase
	endfunction

	// ==========================================================
	// next-state logic
	always_comb
	begin
		logic       tick;
		logic       rx;
		logic [2:0] last_k;
		logic       sda_in;
		n = s;
		n.sda_s = {s.sda_s[0], bus.sda};
		sda_in = s.sda_s[1];
		tick = (s.cnt == 16'h0000);
		n.cnt = tick ? (s.div - 16'h0001) : (s.cnt - 16'h0001);
		rx = s.op_rd && s.k >= 3'd3;
		last_k = s.op_rd ? (s.crc_on ? 3'd7 : 3'd6) : 3'd5;
		// avalon slave: one wait cycle on every access
		n.wait_q = ~((avs_read | avs_write) & s.wait_q);
		if (avs_read && s.wait_q)
		begin
			case (avs_address)
				AV_CMD:    n.rdata = {7'h00, s.crc_on, 1'b0, s.tgt,
					s.reg_a, 7'h00, s.op_rd};
				AV_WDATA:  n.rdata = s.wdata;
				AV_RDATA:  n.rdata = s.rxdata;
				AV_STATUS: n.rdata = {16'h0000, s.crc_rx, 6'h00,
					s.nack, s.busy};
				AV_DIV:    n.rdata = {16'h0000, s.div};
				default:   n.rdata = 32'h00000000;
			endcase
		end
		if (avs_write && !s.wait_q)
		begin
			case (avs_address)
				AV_CMD:
					if (!s.busy)
					begin
						n.op_rd = avs_writedata[CMD_RD_BIT];
						n.reg_a = avs_writedata[CMD_REG_LSB +: 8];
						n.tgt = avs_writedata[CMD_TGT_LSB +: 7];
						n.crc_on = avs_writedata[CMD_CRC_BIT];
						n.busy = 1'b1;
						n.nack = 1'b0;
						n.st = H_START;
						n.ph = 2'd0;
						n.k = 3'd0;
					end
				AV_WDATA: n.wdata = avs_writedata;
				AV_DIV:   n.div = avs_writedata[15:0];
				default:  n.div = s.div;
			endcase
		end
		// bus sequencer, four phases per bit
		if (tick && s.st != H_IDLE)
		begin
			n.ph = s.ph + 2'd1;
			case (s.st)
				H_START:
					case (s.ph)
						2'd0: n.sda_oe = 1'b0;
						2'd1: n.scl_oe = 1'b0;
						2'd2: n.sda_oe = 1'b1;
						default:
						begin
							n.scl_oe = 1'b1;
							n.st = H_BIT;
							n.bitc = 4'd0;
							n.sh = tx_byte(s.k, s.op_rd, s.tgt, s.reg_a,
								s.wdata);
						end
					endcase
				H_BIT:
					case (s.ph)
						2'd0:
							if (s.bitc == 4'd8)
								n.sda_oe = rx && s.k != last_k;
							else
								n.sda_oe = !rx && !s.sh[7];
						2'd1: n.scl_oe = 1'b0;
						2'd2:
							if (s.bitc != 4'd8)
								n.sh = {s.sh[6:0], sda_in};
							else if (!rx)
								n.nack = s.nack | sda_in;
						default:
						begin
							n.scl_oe = 1'b1;
							n.bitc = s.bitc + 4'd1;
							if (s.bitc == 4'd8)
							begin
								n.bitc = 4'd0;
								if (rx && s.k == 3'd7)
									n.crc_rx = s.sh;
								else if (rx)
									n.rxdata = {s.rxdata[23:0], s.sh};
								if (s.nack || s.k == last_k)
									n.st = H_STOP;
								else if (s.op_rd && s.k == 3'd1)
								begin
									n.st = H_START;
									n.k = 3'd2;
								end
								else
								begin
									n.k = s.k + 3'd1;
									n.sh = tx_byte(n.k, s.op_rd, s.tgt,
										s.reg_a, s.wdata);
								end
							end
						end
					endcase
				H_STOP:
					case (s.ph)
						2'd0: n.sda_oe = 1'b1;
						2'd1: n.scl_oe = 1'b0;
						2'd2: n.sda_oe = 1'b0;
						default:
						begin
							n.st = H_IDLE;
							n.busy = 1'b0;
						end
					endcase
				default: n.st = H_IDLE;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= H_IDLE;
			s.wait_q <= 1'b1;
			s.div <= SCL_QTR_CYC;
			s.sda_s <= 2'b11;
		end
		else
			s <= n;
	end

	assign avs_readdata = s.rdata;
	assign avs_waitrequest = s.wait_q;
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = s.scl_oe;
	assign bus.sda_h_o = 1'b0;
	assign bus.sda_h_oe = s.sda_oe;

endmodule

//--- verilog/i2c_link_if.sv
`timescale 1ns/100ps
// open-drain two-wire link; a line is low while any enabled driver is low
interface i2c_link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// ==========================================================
	// wired-and resolution
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);

	modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl, sda);
	modport dev  (output sda_d_o, sda_d_oe, input scl, sda);
endinterface

//--- verilog/i2c_port_pkg.sv
package i2c_port_pkg;

	// ==========================================================
	// device register map
	localparam logic [7:0]  REG_CFG      = 8'h02;
	localparam int          CFG_CRC_BIT  = 18;
	localparam int          CFG_ADDR_LSB = 10;
	localparam logic [7:0]  REG_SLEEP    = 8'h27;
	localparam int          LOOP_LSB     = 2;
	localparam logic [7:0]  REG_XYZ      = 8'h28;
	localparam logic [7:0]  REG_AUX      = 8'h29;
	localparam logic [7:0]  REG_KEY      = 8'h35;
	localparam logic [31:0] KEY_VALUE    = 32'h2C413534;
	localparam int          MEM_WORDS    = 64;
	localparam int          MEM_AW       = 6;
	localparam logic [31:0] MEM_RESET    = 32'h00000000;
	localparam logic [6:0]  ADDR_BASE    = 7'h60;
	localparam logic [7:0]  CRC_POLY     = 8'h07;
	localparam logic [7:0]  CRC_INIT     = 8'h00;

	// ==========================================================
	// controller register map (avalon byte offsets)
	localparam logic [4:0]  AV_CMD       = 5'h00;
	localparam logic [4:0]  AV_WDATA     = 5'h04;
	localparam logic [4:0]  AV_RDATA     = 5'h08;
	localparam logic [4:0]  AV_STATUS    = 5'h0C;
	localparam logic [4:0]  AV_DIV       = 5'h10;
	localparam int          CMD_RD_BIT   = 0;
	localparam int          CMD_REG_LSB  = 8;
	localparam int          CMD_TGT_LSB  = 16;
	localparam int          CMD_CRC_BIT  = 24;

	// ==========================================================
	// bus timing
	localparam int          CLK_NS       = 40;
	localparam int          SCL_QTR_NS   = 2500;
	localparam logic [15:0] SCL_QTR_CYC  =
		16'((SCL_QTR_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK
	} dev_state_t;

	typedef enum logic [1:0] {
		H_IDLE, H_START, H_BIT, H_STOP
	} host_state_t;

endpackage

//--- verilog/sensor_i2c_target.sv
`timescale 1ns/100ps
// sensor register port, target end of the two-wire link
module sensor_i2c_target
	import i2c_port_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	i2c_link_if.dev          bus,
	input  wire logic        addr_select_pin_low,
	input  wire logic        addr_select_pin_high,
	input  wire logic [11:0] x_data,
	input  wire logic [11:0] y_data,
	input  wire logic [11:0] z_data,
	input  wire logic [11:0] temp_data,
	output logic             unlocked,
	output logic [1:0]       sleep_mode
);

	typedef logic [MEM_WORDS-1:0][31:0] mem_t;

	typedef struct packed {
		logic [2:0]  scl_s;
		logic [2:0]  sda_s;
		logic [1:0]  pin_l;
		logic [1:0]  pin_h;
		dev_state_t  st;
		logic [3:0]  bitc;
		logic [7:0]  sh;
		logic [7:0]  ptr;
		logic [7:0]  abyte;
		logic        rw;
		logic [2:0]  bidx;
		logic        first;
		logic        acked;
		logic [31:0] wdata;
		logic [31:0] tx;
		logic [7:0]  crc;
		logic        unlock;
		logic        oe;
		mem_t        mem;
	} dev_s_t;

	dev_s_t s;
	dev_s_t n;

	// ==========================================================
	// helpers
	// one byte through the crc, msb first, zero start, no reflection
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		return r;
	endfunction

	// word seen by a read of register p
	function automatic logic [31:0] rd_word(input logic [7:0] p,
		input mem_t m, input logic [11:0] x, input logic [11:0] y,
		input logic [11:0] z, input logic [11:0] t);
		logic [31:0] w;
		w = 32'h00000000;
		if (p == REG_XYZ)
			w = {x[11:4], y[11:4], z[11:4], 2'b00, t[11:6]};
		else if (p == REG_AUX)
			w = {14'h0000, t[5:0], x[3:0], y[3:0], z[3:0]};
		else if (p[7:MEM_AW] == '0)
			w = m[p[MEM_AW-1:0]];
		return w;
	endfunction

	// register after p in a continued read, per readback mode
	function automatic logic [7:0] next_ptr(input logic [7:0] p,
		input logic [1:0] mode);
		logic [7:0] q;
		q = p + 8'h01;
		if (mode == 2'b01)
			q = REG_XYZ;
		else if (mode == 2'b10)
			q = (p == REG_XYZ) ? REG_AUX : REG_XYZ;
		return q;
	endfunction

	// ==========================================================
	// next-state logic
	always_comb
	begin
		logic       rise;
		logic       fall;
		logic       sda_in;
		logic       start;
		logic       stop;
		logic [1:0] mode;
		logic       loop;
		logic       crc_en;
		logic [6:0] my_addr;
		logic [7:0] cur;
		logic [7:0] nb;
		logic [7:0] np;
		logic [7:0] p0;
		logic [31:0] wfull;
		logic [31:0] ntx;
		my_addr = ADDR_BASE;
		n = s;
		n.scl_s = {s.scl_s[1:0], bus.scl};
		n.sda_s = {s.sda_s[1:0], bus.sda};
		n.pin_l = {s.pin_l[0], addr_select_pin_low};
		n.pin_h = {s.pin_h[0], addr_select_pin_high};
		rise = s.scl_s[1] & ~s.scl_s[2];
		fall = ~s.scl_s[1] & s.scl_s[2];
		sda_in = s.sda_s[1];
		start = s.scl_s[1] & s.scl_s[2] & s.sda_s[2] & ~s.sda_s[1];
		stop = s.scl_s[1] & s.scl_s[2] & ~s.sda_s[2] & s.sda_s[1];
		mode = s.mem[REG_SLEEP[MEM_AW-1:0]][LOOP_LSB +: 2];
		loop = mode[0] ^ mode[1];
		crc_en = s.mem[REG_CFG[MEM_AW-1:0]][CFG_CRC_BIT];
		if (s.pin_h[1] & s.pin_l[1])
			my_addr = s.mem[REG_CFG[MEM_AW-1:0]][CFG_ADDR_LSB +: 7];
		else
			my_addr = ADDR_BASE
				| {3'b000, s.pin_h[1], s.pin_h[1],
				s.pin_l[1], s.pin_l[1]};
		cur = s.bidx[2] ? s.crc : s.tx[{~s.bidx[1:0], 3'b000} +: 8];
		np = next_ptr(s.ptr, mode);
		p0 = loop ? REG_XYZ : s.ptr;
		wfull = {s.wdata[23:0], s.sh};
		ntx = rd_word(np, s.mem, x_data, y_data, z_data, temp_data);
		nb = ntx[31:24];
		// shift in received bits on scl rise
		if (rise && (s.st == S_ADDR || s.st == S_RX))
		begin
			n.sh = {s.sh[6:0], sda_in};
			n.bitc = s.bitc + 4'd1;
		end
		if (rise && s.st == S_TACK)
			n.acked = ~sda_in;
		// framing conditions win over everything else
		if (start)
		begin
			n.st = S_ADDR;
			n.bitc = 4'd0;
			n.oe = 1'b0;
			n.first = 1'b1;
			n.bidx = 3'd0;
		end
		else if (stop)
		begin
			n.st = S_IDLE;
			n.oe = 1'b0;
		end
		else if (fall)
		begin
			case (s.st)
				S_ADDR:
					if (s.bitc == 4'd8)
					begin
						n.bitc = 4'd0;
						if (s.sh[7:1] == my_addr)
						begin
							n.oe = 1'b1;
							n.st = S_AACK;
							n.rw = s.sh[0];
							n.abyte = s.sh;
							if (s.sh[0])
							begin
								n.ptr = p0;
								n.tx = rd_word(p0, s.mem, x_data, y_data,
									z_data, temp_data);
								n.crc = crc8(crc8(CRC_INIT, p0), s.sh);
								n.bidx = 3'd0;
							end
						end
						else
							n.st = S_IDLE;
					end
				S_AACK:
					if (s.rw)
					begin
						n.st = S_TX;
						n.oe = ~cur[7];
						n.bitc = 4'd1;
					end
					else
					begin
						n.st = S_RX;
						n.oe = 1'b0;
						n.bitc = 4'd0;
					end
				S_RX:
					if (s.bitc == 4'd8)
					begin
						n.oe = 1'b1;
						n.st = S_RACK;
						n.bitc = 4'd0;
						if (s.first)
						begin
							n.ptr = s.sh;
							n.first = 1'b0;
						end
						else
						begin
							n.wdata = wfull;
							n.bidx = s.bidx + 3'd1;
							if (s.bidx == 3'd3)
							begin
								n.bidx = 3'd0;
								n.ptr = s.ptr + 8'h01;
								if (s.ptr == REG_KEY && wfull == KEY_VALUE)
									n.unlock = 1'b1;
								else if ((s.unlock || s.ptr == REG_SLEEP)
									&& s.ptr[7:MEM_AW] == '0)
									n.mem[s.ptr[MEM_AW-1:0]] = wfull;
							end
						end
					end
				S_RACK:
				begin
					n.oe = 1'b0;
					n.st = S_RX;
				end
				S_TX:
					if (s.bitc == 4'd8)
					begin
						n.oe = 1'b0;
						n.st = S_TACK;
					end
					else
					begin
						n.oe = ~cur[~s.bitc[2:0]];
						n.bitc = s.bitc + 4'd1;
					end
				S_TACK:
					if (s.acked)
					begin
						n.st = S_TX;
						n.bitc = 4'd1;
						n.crc = crc8(s.crc, cur);
						if (s.bidx < 3'd3)
						begin
							n.bidx = s.bidx + 3'd1;
							nb = s.tx[{~n.bidx[1:0], 3'b000} +: 8];
						end
						else if (s.bidx == 3'd3 && crc_en)
						begin
							n.bidx = 3'd4;
							nb = n.crc;
						end
						else
						begin
							n.bidx = 3'd0;
							n.ptr = np;
							n.tx = ntx;
							n.crc = crc8(crc8(CRC_INIT, np), s.abyte);
						end
						n.oe = ~nb[7];
					end
					else
					begin
						n.st = S_IDLE;
						n.oe = 1'b0;
					end
				default:
					n.st = S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// state register; reset stands for power-up
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= S_IDLE;
			s.mem <= {MEM_WORDS{MEM_RESET}};
			s.scl_s <= 3'b111;
			s.sda_s <= 3'b111;
		end
		else
			s <= n;
	end

	assign bus.sda_d_o = 1'b0;
	assign bus.sda_d_oe = s.oe;
	assign unlocked = s.unlock;
	assign sleep_mode = s.mem[REG_SLEEP[MEM_AW-1:0]][1:0];

endmodule
